// ---- src/nvl_cmd_front.sv ----
// command decoder and access lock tracker for the shared non-volatile memory
// Notes on behaviour
// [R1] memory access is granted to the host only while it holds the lock
// [R2] host must hold the lock before sending other manager commands
// [R3] 8500 requests the lock, no parameters, asynchronous; acceptance is not grant
// [R4] accepted request answers success; lock already held answers already-held
// [R5] request while an earlier one is pending answers pending
// [R6] host releases the lock when finished with the memory
// [R7] 8501 is a synchronous lock query, 8502 a synchronous release
// [R8] 8503 bus configuration and 850a device configuration are synchronous
// [R9] 8504 read, 8505 write, 8506 block erase are asynchronous
// [R10] 8507 erase, 8508 query asynchronous; 8509 operation status synchronous
// [R11] 850d validation asynchronous, 850e its status synchronous
// [R12] 850f issues device command asynchronously, 8510 returns its response
// [R13] bus config is 48 bits, starting with 32-bit speed within limits
// [R14] bus mode field accepts 0 for mode 0 and 3 for mode 3
// [R15] read mode 0 selects opcode 03, 1 selects opcode 0b
// [R16] device config is 64 bits with memory_driver_selector 0, 1 or 2
// [R17] device config holds read selector, address width bytes, reserved byte
// [R18] device config ends with 32-bit memory size in bytes
// [R19] commands needing the lock answer access denied without it
// [R20] lock query answers success once held, pending while still pending
// [R21] unknown codes answer unsupported and leave the lock alone
module nvl_cmd_front
  import nvl_pkg::*;
#(
  parameter logic [31:0] SPEED_MIN = 32'h000f_4240,  // lowest bus speed, hz
  parameter logic [31:0] SPEED_MAX = 32'h02fa_f080   // highest bus speed, hz
) (
  input  wire logic                 clk_sys,        // system clock
  input  wire logic                 rst,            // synchronous reset, high
  input  wire logic                 clkEn,          // freezes all state when low, unless rst is high
  input  wire logic                 cmdValid,       // host command strobe
  input  wire logic [CMD_W-1:0]     cmdCode,        // 16-bit command code
  input  wire logic [BUS_CFG_W-1:0] busCfgIn,       // bus config parameter
  input  wire logic [DEV_CFG_W-1:0] devCfgIn,       // device config parameter
  input  wire logic                 lockGrant,      // internal owners let go, lock granted
  output logic                      rspValid,       // answer strobe
  output logic [2:0]                rspStatus,      // result status code
  output logic [1:0]                rspKind,        // sync, async or none
  output logic                      lockHeld,       // host owns the memory
  output logic                      lockPending,    // request waiting for grant
  output logic                      lockReq,        // asks internal owners to yield
  output logic                      opStart,        // async memory operation launch
  output logic [CMD_W-1:0]          opCode,         // code of last launched operation or sync query
  output logic [31:0]               spiSpeed,       // configured bus speed
  output logic [7:0]                spiMode,        // configured bus mode
  output logic [7:0]                readOpcode,     // opcode for bus reads
  output logic [7:0]                memoryDriverSelector, // memory_driver_selector
  output logic [7:0]                devReadOpcode,  // device read opcode
  output logic [7:0]                addrWidth,      // address width in bytes
  output logic [31:0]               devSize         // device size in bytes
);

  // classifies a code; unknown codes come back as none
  function automatic nvl_kind_t kind_of(input logic [CMD_W-1:0] c);
    case (c)
      CMD_LOCK_REQUEST, CMD_READ, CMD_WRITE, CMD_ERASE_BLOCK,
      CMD_ERASE_DEVICE, CMD_QUERY_DEVICE, CMD_VALIDATE,
      CMD_DEV_COMMAND:                                  kind_of = KIND_ASYNC; // [R3] [R9] [R10] [R11] [R12]
      CMD_LOCK_STATUS, CMD_LOCK_RELEASE, CMD_BUS_CONFIG,
      CMD_DEVICE_CONFIG, CMD_OP_STATUS, CMD_VALIDATE_STAT,
      CMD_DEV_RESPONSE:                                 kind_of = KIND_SYNC;  // [R7] [R8] [R10] [R11] [R12]
      default:                                          kind_of = KIND_NONE;
    endcase
  endfunction

  // maps the standard/fast selector to an opcode, shared by both configs
  function automatic logic [7:0] opcode_of(input logic [7:0] sel);
    opcode_of = (sel == READ_FAST) ? OPCODE_FAST : OPCODE_STANDARD; // [R15] [R17]
  endfunction

  function automatic logic sel_ok(input logic [7:0] sel);
    sel_ok = (sel == READ_STANDARD) || (sel == READ_FAST);
  endfunction

  nvl_lock_t   lockState, next_lockState;
  logic        next_rspValid, next_opStart;
  logic [2:0]  next_rspStatus;
  logic [1:0]  next_rspKind;
  logic [CMD_W-1:0] next_opCode;
  logic [31:0] next_spiSpeed, next_devSize;
  logic [7:0]  next_spiMode, next_readOpcode, next_driver, next_devReadOpcode, next_addrWidth;

  // parameter fields
  logic [31:0] cfgSpeed;
  logic [7:0]  cfgMode, cfgRead, devDriver, devRead, devAwidth;
  logic [31:0] devSizeIn;
  assign cfgSpeed  = busCfgIn[BUS_SPEED_LSB +: 32];  // [R13]
  assign cfgMode   = busCfgIn[BUS_MODE_LSB +: 8];
  assign cfgRead   = busCfgIn[BUS_READ_LSB +: 8];
  assign devDriver = devCfgIn[DEV_DRIVER_LSB +: 8];  // [R16]
  assign devRead   = devCfgIn[DEV_READ_LSB +: 8];    // [R17]
  assign devAwidth = devCfgIn[DEV_AWIDTH_LSB +: 8];  // [R17] reserved byte sits below, ignored
  assign devSizeIn = devCfgIn[DEV_SIZE_LSB +: 32];   // [R18]

  logic busCfgOk, devCfgOk;
  assign busCfgOk = (cfgSpeed >= SPEED_MIN) && (cfgSpeed <= SPEED_MAX)  // [R13]
                    && ((cfgMode == SPI_MODE_0) || (cfgMode == SPI_MODE_3)) // [R14]
                    && sel_ok(cfgRead);                                    // [R15]
  assign devCfgOk = (devDriver <= DRIVER_EEPROM_RW) && sel_ok(devRead);   // [R16] [R17]

  // command handling; a release while pending is refused, so a grant landing with it still holds
  always_comb begin
    nvl_kind_t k;
    k = kind_of(cmdCode);
    next_lockState     = lockState;
    next_rspValid      = 1'b0;
    next_rspStatus     = rspStatus;
    next_rspKind       = rspKind;
    next_opStart       = 1'b0;
    next_opCode        = opCode;
    next_spiSpeed      = spiSpeed;
    next_spiMode       = spiMode;
    next_readOpcode    = readOpcode;
    next_driver        = memoryDriverSelector;
    next_devReadOpcode = devReadOpcode;
    next_addrWidth     = addrWidth;
    next_devSize       = devSize;
    if (lockState == LK_PENDING && lockGrant) begin
      next_lockState = LK_HELD;
    end
    if (cmdValid) begin
      next_rspValid = 1'b1;
      next_rspKind  = k;
      case (cmdCode)
        CMD_LOCK_REQUEST: begin
          case (lockState)
            LK_HELD:    next_rspStatus = STATUS_LOCK_ALREADY_HELD; // [R4]
            LK_PENDING: next_rspStatus = STATUS_PENDING;           // [R5]
            default: begin
              next_rspStatus = STATUS_SUCCESS;  // [R3] [R4] accepted, not yet granted
              next_lockState = LK_PENDING;
            end
          endcase
        end
        CMD_LOCK_STATUS: begin
          // held answers success; pending and free both read as not complete
          next_rspStatus = (lockState == LK_HELD) ? STATUS_SUCCESS : STATUS_PENDING; // [R20]
        end
        CMD_LOCK_RELEASE: begin
          if (lockState == LK_PENDING) begin
            next_rspStatus = STATUS_PENDING;
          end else begin
            next_rspStatus = STATUS_SUCCESS;   // [R6]
            next_lockState = LK_FREE;
          end
        end
        default: begin
          if (k == KIND_NONE) begin
            next_rspStatus = STATUS_UNSUPPORTED;   // [R21]
          end else if (lockState != LK_HELD) begin
            next_rspStatus = STATUS_ACCESS_DENIED; // [R1] [R2] [R19]
          end else if (cmdCode == CMD_BUS_CONFIG) begin
            next_rspStatus = busCfgOk ? STATUS_SUCCESS : STATUS_INVALID;
            if (busCfgOk) begin
              next_spiSpeed   = cfgSpeed;
              next_spiMode    = cfgMode;
              next_readOpcode = opcode_of(cfgRead);
            end
          end else if (cmdCode == CMD_DEVICE_CONFIG) begin
            next_rspStatus = devCfgOk ? STATUS_SUCCESS : STATUS_INVALID;
            if (devCfgOk) begin
              next_driver        = devDriver;
              next_devReadOpcode = opcode_of(devRead);
              next_addrWidth     = devAwidth;
              next_devSize       = devSizeIn;
            end
          end else begin
            next_rspStatus = STATUS_SUCCESS;
            // async codes launch downstream; sync queries answer success here with no launch
            next_opStart   = (k == KIND_ASYNC);    // [R1]
            next_opCode    = cmdCode;
          end
        end
      endcase
    end
  end

  // registers; every output is a flip-flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lockState            <= LK_FREE;
      rspValid             <= 1'b0;
      rspStatus            <= STATUS_SUCCESS;
      rspKind              <= KIND_NONE;
      opStart              <= 1'b0;
      opCode               <= '0;
      spiSpeed             <= SPEED_MIN;
      spiMode              <= RST_SPI_MODE;
      readOpcode           <= OPCODE_STANDARD;
      memoryDriverSelector <= RST_DRIVER;
      devReadOpcode        <= OPCODE_STANDARD;
      addrWidth            <= RST_AWIDTH;
      devSize              <= RST_DEV_SIZE;
      lockHeld             <= 1'b0;
      lockPending          <= 1'b0;
      lockReq              <= 1'b0;
    end else if (clkEn) begin
      lockState            <= next_lockState;
      rspValid             <= next_rspValid;
      rspStatus            <= next_rspStatus;
      rspKind              <= next_rspKind;
      opStart              <= next_opStart;
      opCode               <= next_opCode;
      spiSpeed             <= next_spiSpeed;
      spiMode              <= next_spiMode;
      readOpcode           <= next_readOpcode;
      memoryDriverSelector <= next_driver;
      devReadOpcode        <= next_devReadOpcode;
      addrWidth            <= next_addrWidth;
      devSize              <= next_devSize;
      lockHeld             <= (next_lockState == LK_HELD);    // [R1]
      lockPending          <= (next_lockState == LK_PENDING);
      lockReq              <= (next_lockState != LK_FREE);
    end
  end

endmodule

// ---- src/nvl_pkg.sv ----
// package of command codes, status codes, parameter encodings and reset values for the lock front end
package nvl_pkg;
  localparam int CMD_W = 16;
  localparam logic [15:0] CMD_LOCK_REQUEST   = 16'h8500;
  localparam logic [15:0] CMD_LOCK_STATUS    = 16'h8501;
  localparam logic [15:0] CMD_LOCK_RELEASE   = 16'h8502;
  localparam logic [15:0] CMD_BUS_CONFIG     = 16'h8503;
  localparam logic [15:0] CMD_READ           = 16'h8504;
  localparam logic [15:0] CMD_WRITE          = 16'h8505;
  localparam logic [15:0] CMD_ERASE_BLOCK    = 16'h8506;
  localparam logic [15:0] CMD_ERASE_DEVICE   = 16'h8507;
  localparam logic [15:0] CMD_QUERY_DEVICE   = 16'h8508;
  localparam logic [15:0] CMD_OP_STATUS      = 16'h8509;
  localparam logic [15:0] CMD_DEVICE_CONFIG  = 16'h850a;
  localparam logic [15:0] CMD_VALIDATE       = 16'h850d;
  localparam logic [15:0] CMD_VALIDATE_STAT  = 16'h850e;
  localparam logic [15:0] CMD_DEV_COMMAND    = 16'h850f;
  localparam logic [15:0] CMD_DEV_RESPONSE   = 16'h8510;

  // result status codes, encodings chosen locally
  localparam logic [2:0] STATUS_SUCCESS           = 3'h0;
  localparam logic [2:0] STATUS_PENDING           = 3'h1;
  localparam logic [2:0] STATUS_LOCK_ALREADY_HELD = 3'h2;
  localparam logic [2:0] STATUS_ACCESS_DENIED     = 3'h3;
  localparam logic [2:0] STATUS_UNSUPPORTED       = 3'h4;
  localparam logic [2:0] STATUS_INVALID           = 3'h5;

  // bus configuration parameter layout (48 bits, first field in the top bits)
  localparam int BUS_CFG_W        = 48;
  localparam int BUS_SPEED_LSB    = 16;
  localparam int BUS_MODE_LSB     = 8;
  localparam int BUS_READ_LSB     = 0;
  localparam logic [7:0] SPI_MODE_0 = 8'h00;
  localparam logic [7:0] SPI_MODE_3 = 8'h03;
  localparam logic [7:0] READ_STANDARD = 8'h00;
  localparam logic [7:0] READ_FAST     = 8'h01;
  localparam logic [7:0] OPCODE_STANDARD = 8'h03;
  localparam logic [7:0] OPCODE_FAST     = 8'h0b;

  // device configuration parameter layout (64 bits)
  localparam int DEV_CFG_W        = 64;
  localparam int DEV_DRIVER_LSB   = 56;
  localparam int DEV_READ_LSB     = 48;
  localparam int DEV_AWIDTH_LSB   = 40;
  localparam int DEV_SIZE_LSB     = 0;
  localparam logic [7:0] DRIVER_READ_ONLY = 8'h00;
  localparam logic [7:0] DRIVER_FLASH_RW  = 8'h01;
  localparam logic [7:0] DRIVER_EEPROM_RW = 8'h02;

  // reset values of the configuration
  localparam logic [7:0]  RST_SPI_MODE   = 8'h00;
  localparam logic [7:0]  RST_READ_MODE  = 8'h00;
  localparam logic [7:0]  RST_DRIVER     = 8'h00;
  localparam logic [7:0]  RST_AWIDTH     = 8'h03;
  localparam logic [31:0] RST_DEV_SIZE   = 32'h0000_0000;

  // command kind reported with each answer
  typedef enum logic [1:0] {KIND_SYNC, KIND_ASYNC, KIND_NONE} nvl_kind_t;
  typedef enum logic [1:0] {LK_FREE, LK_PENDING, LK_HELD} nvl_lock_t;
endpackage

// ---- tb/nvl_cmd_front_sva.sv ----
// concurrent checks on the ports of the lock front end
module nvl_cmd_front_sva
  import nvl_pkg::*;
(
  input wire logic             clk_sys,     // clock
  input wire logic             rst,         // synchronous reset
  input wire logic             clkEn,       // clock enable
  input wire logic             cmdValid,    // command strobe
  input wire logic [CMD_W-1:0] cmdCode,     // command code
  input wire logic             lockGrant,   // owners yielded
  input wire logic             rspValid,    // answer strobe
  input wire logic [2:0]       rspStatus,   // status code
  input wire logic [1:0]       rspKind,     // command kind
  input wire logic             lockHeld,    // lock owned
  input wire logic             lockPending, // lock awaited
  input wire logic             opStart      // async launch
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic tk;
  logic known;
  logic gated;
  // a command counts only when the enable lets it in
  assign tk = clkEn && cmdValid;
  assign known = cmdCode inside {[CMD_LOCK_REQUEST:CMD_DEVICE_CONFIG], [CMD_VALIDATE:CMD_DEV_RESPONSE]};
  assign gated = known && !(cmdCode inside {[CMD_LOCK_REQUEST:CMD_LOCK_RELEASE]});
  AST_ANSWER: assert property (tk |=> rspValid)
    else $error("command not answered");
  AST_UNSUP: assert property (tk && !known && !lockGrant |=> rspStatus == STATUS_UNSUPPORTED
    && rspKind == KIND_NONE && $stable(lockHeld) && $stable(lockPending))
    else $error("unknown code mishandled");
  AST_DENY: assert property (tk && gated && !lockHeld |=>
    rspStatus == STATUS_ACCESS_DENIED && !opStart) else $error("no denial without lock");
  AST_ACCEPT: assert property (tk && cmdCode == CMD_LOCK_REQUEST && !lockHeld && !lockPending
    |=> rspStatus == STATUS_SUCCESS && rspKind == KIND_ASYNC && lockPending && !lockHeld)
    else $error("lock request not accepted");
  AST_BUSY: assert property (tk && cmdCode == CMD_LOCK_REQUEST && lockPending
    |=> rspStatus == STATUS_PENDING) else $error("pending request not busy");
  AST_ALREADY: assert property (tk && cmdCode == CMD_LOCK_REQUEST && lockHeld
    |=> rspStatus == STATUS_LOCK_ALREADY_HELD && lockHeld) else $error("held lock not reported");
  AST_RELEASE: assert property (tk && cmdCode == CMD_LOCK_RELEASE && lockHeld
    |=> !lockHeld && !lockPending && rspStatus == STATUS_SUCCESS) else $error("release failed");
  AST_GRANT: assert property (clkEn && lockPending && lockGrant
    && !(tk && cmdCode == CMD_LOCK_RELEASE) |=> lockHeld) else $error("grant lost");
  AST_LAUNCH: assert property (opStart |-> rspValid && rspKind == KIND_ASYNC
    && $past(lockHeld)) else $error("launch without lock");
  AST_ASYNC: assert property (tk && lockHeld && cmdCode inside {[CMD_READ:CMD_QUERY_DEVICE]}
    |=> opStart && rspStatus == STATUS_SUCCESS) else $error("memory op not launched");
endmodule

bind nvl_cmd_front nvl_cmd_front_sva uChk (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .lockGrant(lockGrant), .rspValid(rspValid),
  .rspStatus(rspStatus), .rspKind(rspKind), .lockHeld(lockHeld), .lockPending(lockPending),
  .opStart(opStart));

// ---- tb/nvl_cmd_front_tb.sv ----
// self-checking bench: reference model compared with the front end every cycle
module nvl_cmd_front_tb;
  import nvl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SMIN = 32'h000f_4240;
  localparam logic [31:0] SMAX = 32'h02fa_f080;
  logic        clk_sys, rst, clkEn, cmdValid, lockGrant, rspValid, lockHeld, lockPending;
  logic        lockReq, opStart, eV, eO;
  logic [15:0] cmdCode, opCode, eC;
  logic [47:0] busCfgIn, nBus;
  logic [63:0] devCfgIn, nDev;
  logic [2:0]  rspStatus, eS;
  logic [1:0]  rspKind;
  nvl_kind_t   eK;
  logic [3:0]  dly;
  logic [31:0] spiSpeed, devSize, x, t, u;
  logic [7:0]  spiMode, readOpcode, memoryDriverSelector, devReadOpcode, addrWidth;
  logic [103:0] eCfg;
  int          lk, n_mismatch, samples_checked, cyc;
  // unknown codes first, release last so a sweep ends by freeing the lock
  logic [15:0] codes [18] = '{16'h850b, 16'h8511, 16'h0000, 16'h8500, 16'h8501, 16'h8503,
    16'h8504, 16'h8505, 16'h8506, 16'h8507, 16'h8508, 16'h8509, 16'h850a, 16'h850d,
    16'h850e, 16'h850f, 16'h8510, 16'h8502};
  logic [47:0] bcs [6] = '{{SMIN - 32'h1, 16'h0000}, {SMAX, 16'h0301}, {SMAX + 32'h1, 16'h0000},
    {SMIN, 16'h0100}, {SMIN, 16'h0002}, {SMIN, 16'h0000}};

  nvl_cmd_front #(.SPEED_MIN(SMIN), .SPEED_MAX(SMAX)) uut (.clk_sys(clk_sys), .rst(rst),
    .clkEn(clkEn), .cmdValid(cmdValid), .cmdCode(cmdCode), .busCfgIn(busCfgIn),
    .devCfgIn(devCfgIn), .lockGrant(lockGrant), .rspValid(rspValid), .rspStatus(rspStatus),
    .rspKind(rspKind), .lockHeld(lockHeld), .lockPending(lockPending), .lockReq(lockReq),
    .opStart(opStart), .opCode(opCode), .spiSpeed(spiSpeed), .spiMode(spiMode),
    .readOpcode(readOpcode), .memoryDriverSelector(memoryDriverSelector),
    .devReadOpcode(devReadOpcode), .addrWidth(addrWidth), .devSize(devSize));
  nvl_owner_model owner (.clk_sys(clk_sys), .rst(rst), .lockReq(lockReq), .delay(dly),
    .lockGrant(lockGrant));

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, well above the length of the sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  function automatic nvl_kind_t kindOf(input logic [15:0] c);
    if (c inside {CMD_LOCK_REQUEST, [CMD_READ:CMD_QUERY_DEVICE], CMD_VALIDATE, CMD_DEV_COMMAND})
      return KIND_ASYNC;
    if (c inside {[CMD_LOCK_STATUS:CMD_BUS_CONFIG], CMD_OP_STATUS, CMD_DEVICE_CONFIG,
      CMD_VALIDATE_STAT, CMD_DEV_RESPONSE}) return KIND_SYNC;
    return KIND_NONE;
  endfunction

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // reference model: advances on the inputs sampled at this edge
  task automatic mdl();
    logic g;
    g = 1'b0;
    if (rst) begin
      lk = 0;
      eV = 1'b0;
      eO = 1'b0;
      eS = STATUS_SUCCESS;
      eK = KIND_NONE;
      eC = 16'h0;
      eCfg = {SMIN, RST_SPI_MODE, OPCODE_STANDARD, RST_DRIVER, OPCODE_STANDARD, RST_AWIDTH,
        RST_DEV_SIZE};
    end else if (clkEn) begin
      g = lk == 1 && lockGrant;
      eV = cmdValid;
      eO = 1'b0;
      if (cmdValid) begin
        eK = kindOf(cmdCode);
        if (eK == KIND_NONE) eS = STATUS_UNSUPPORTED;
        else if (cmdCode == CMD_LOCK_REQUEST) begin
          eS = lk == 0 ? STATUS_SUCCESS : (lk == 1 ? STATUS_PENDING : STATUS_LOCK_ALREADY_HELD);
          lk = lk == 0 ? 1 : lk;
        end else if (cmdCode == CMD_LOCK_STATUS) eS = lk == 2 ? STATUS_SUCCESS : STATUS_PENDING;
        else if (cmdCode == CMD_LOCK_RELEASE) begin
          eS = lk == 1 ? STATUS_PENDING : STATUS_SUCCESS;
          // a release while pending is refused, so a grant landing with it still applies
          if (lk != 1) lk = 0;
        end else if (lk != 2) eS = STATUS_ACCESS_DENIED;
        else if (cmdCode == CMD_BUS_CONFIG) begin
          eS = busCfgIn[47:16] < SMIN || busCfgIn[47:16] > SMAX || busCfgIn[7:0] > 8'h01
            || !(busCfgIn[15:8] inside {SPI_MODE_0, SPI_MODE_3}) ? STATUS_INVALID : STATUS_SUCCESS;
          if (eS == STATUS_SUCCESS) eCfg[103:56] = {busCfgIn[47:8],
            busCfgIn[0] ? OPCODE_FAST : OPCODE_STANDARD};
        end else if (cmdCode == CMD_DEVICE_CONFIG) begin
          eS = devCfgIn[63:56] > 8'h02 || devCfgIn[55:48] > 8'h01 ? STATUS_INVALID : STATUS_SUCCESS;
          if (eS == STATUS_SUCCESS) eCfg[55:0] = {devCfgIn[63:56],
            devCfgIn[48] ? OPCODE_FAST : OPCODE_STANDARD, devCfgIn[47:40], devCfgIn[31:0]};
        end else begin
          {eS, eO, eC} = {STATUS_SUCCESS, eK == KIND_ASYNC, cmdCode};
        end
      end
      if (g) lk = 2;
    end
  endtask

  task automatic step(input logic r, input logic e, input logic v, input logic [15:0] c);
    @(posedge clk_sys);
    mdl();
    rst <= r;
    clkEn <= e;
    cmdValid <= v;
    cmdCode <= c;
    busCfgIn <= nBus;
    devCfgIn <= nDev;
    #1;
    chk(lockHeld === (lk == 2) && lockPending === (lk == 1) && lockReq === (lk != 0), "lock");
    chk(rspValid === eV && opStart === eO, "answer strobe");
    chk(rspStatus === eS && rspKind === eK, "status or kind");
    chk(opCode === eC, "launched code");
    chk({spiSpeed, spiMode, readOpcode, memoryDriverSelector, devReadOpcode, addrWidth,
      devSize} === eCfg, "configuration");
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // directed sweeps first, then seeded random traffic with mid-run resets
  initial begin
    {rst, clkEn, cmdValid, cmdCode, busCfgIn, devCfgIn} = {2'b11, 1'b0, 16'h0, 48'h0, 64'h0};
    {x, dly, n_mismatch, samples_checked, cyc} = {32'd15326, 4'h3, 96'h0};
    nBus = {SMAX, SPI_MODE_3, READ_FAST};
    nDev = {DRIVER_EEPROM_RW, READ_FAST, 8'h04, 8'h00, 32'h0010_0000};
    repeat (8) step(1'b1, 1'b1, 1'b0, 16'h0);
    foreach (codes[i]) step(1'b0, 1'b1, 1'b1, codes[i]);
    step(1'b0, 1'b1, 1'b1, CMD_LOCK_REQUEST);
    step(1'b0, 1'b1, 1'b1, CMD_LOCK_REQUEST);
    for (int i = 0; i < 20 && !lockHeld; i++) step(1'b0, 1'b1, 1'b1, CMD_LOCK_STATUS);
    foreach (codes[i]) step(1'b0, 1'b1, 1'b1, codes[i]);
    step(1'b0, 1'b1, 1'b1, CMD_LOCK_REQUEST);
    for (int i = 0; i < 20 && !lockHeld; i++) step(1'b0, 1'b1, 1'b1, CMD_LOCK_STATUS);
    for (int i = 0; i < 6; i++) begin
      nBus = bcs[i];
      nDev = {8'(i), 8'(i % 2), 8'(i + 1), 8'h00, 32'(i * 1000)};
      step(1'b0, 1'b1, 1'b1, CMD_BUS_CONFIG);
      step(1'b0, 1'b1, 1'b1, CMD_DEVICE_CONFIG);
    end
    step(1'b0, 1'b0, 1'b1, CMD_LOCK_RELEASE);
    repeat (3000) begin
      t = rnd();
      u = rnd();
      dly = t[19:16];
      nBus = {t[3] ? u : SMIN + u % (SMAX - SMIN + 32'h1), 6'h0, t[9:8], 6'h0, t[12:11]};
      nDev = {6'h0, t[21:20], 7'h0, t[22], t[31:24], 8'h00, u};
      step(t[30:23] == 8'h0, t[2:0] != 3'h0, t[3] | t[5], t[4] ? codes[t[28:24] % 18] : u[15:0]);
    end
    end_sim();
  end
endmodule

// ---- tb/nvl_owner_model.sv ----
// internal memory owners: yield the lock to the host after a set hold-off
module nvl_owner_model (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rst,      // synchronous reset
  input  wire logic       lockReq,  // host asks for the memory
  input  wire logic [3:0] delay,    // cycles before yielding
  output logic            lockGrant // owners have let go
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // never grant in the cycle of the request, so acceptance is not the grant
  always_ff @(posedge clk_sys) begin
    cnt       <= (rst || !lockReq) ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
    lockGrant <= !rst && lockReq && cnt >= delay;
  end
endmodule
